/* File: logic/vpi_arbiter.sv */
// Purpose: picks the pending user source with the highest level above the cpu level
// Assumes: pending already gated by flag, enable and implemented-source mask
// Notes: purely combinational
`timescale 1ns/1ps
module vpi_arbiter (
    input wire logic [vpi_pkg::NUM_SRC-1:0] pending,
    input wire vpi_pkg::vpi_prio_arr_t prio,
    input wire logic [3:0] cpu_level,
    output logic found,
    output logic [6:0] idx,
    output logic [2:0] level
);
    import vpi_pkg::*;

    always_comb begin
        logic [3:0] cand;
        cand = 4'h0;
        found = 1'b0;
        idx = 7'h00;
        level = 3'h0;
        // walk downward so an equal level at a lower index takes over
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            cand = {1'b0, prio_field(prio, i)};
            if (pending[i] && cand > cpu_level && (!found || cand[2:0] >= level)) begin
                found = 1'b1;
                idx = 7'(i);
                level = cand[2:0];
            end
        end
    end

endmodule

/* File: logic/vpi_cpu_level.sv */
// Purpose: cpu status word and the high priority level bit
// Assumes: core_flags carries the arithmetic state the core reports each cycle
// Notes: a level load from the core overrides a software write in the same cycle
`timescale 1ns/1ps
module vpi_cpu_level (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sw_we,
    input wire logic [15:0] sw_wdata,
    input wire logic nesting_disable,
    input wire vpi_pkg::vpi_level_load_t load,
    input wire logic [15:0] core_flags,
    output logic [15:0] status_word,
    output logic [3:0] cpu_level
);
    import vpi_pkg::*;

    typedef struct packed {
        logic [15:0] sw;
        logic high;
    } vpi_lvl_state_t;

    vpi_lvl_state_t q;
    vpi_lvl_state_t d;

    always_comb begin
        logic [15:0] rw;
        rw = nesting_disable ? (SW_RW_MASK & ~SW_IPL_MASK) : SW_RW_MASK;
        d = q;
        if (sw_we) begin
            d.sw = (q.sw & ~rw) | (sw_wdata & rw);
            d.sw = (d.sw & ~SW_RC_MASK) | (q.sw & sw_wdata & SW_RC_MASK);
        end
        d.sw = (d.sw & ~SW_HW_MASK) | (core_flags & SW_HW_MASK);
        d.sw = d.sw | (core_flags & SW_RC_MASK);
        if (load.valid) begin
            d.sw[SW_IPL_LSB +: 3] = load.level[2:0];
            d.high = load.level[3];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '{sw: REG_RESET, high: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign status_word = q.sw;
    assign cpu_level = {q.high, q.sw[SW_IPL_LSB +: 3]};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    nest_lock_a: assert property (nesting_disable && sw_we && !load.valid |=> $stable(cpu_level))
        else $error("priority bits changed by software while nesting disabled");
    high_bit_ro_a: assert property (!load.valid |=> $stable(q.high))
        else $error("high priority bit changed without a level load");

endmodule

/* File: logic/vpi_ctrl.sv */
// Summary of operation
// - user request n gets vector n+8; requests 72..117 have no source
// - table entry at base plus twice the vector; alternate entry 0x100 higher
// - trap vectors 1..5: oscillator, address, stack, math, dma; 0, 6, 7 unused
// - thirty-one controller registers: two control, five flag, five enable, eighteen priority, latch
// - each source has a flag set by hardware, held until software clears it
// - a source with a clear enable bit never requests service
// - each user source has a three-bit priority field, eight levels
// - flag, enable and priority bits ascend by request number from bit 0
// - among equal levels the lower request number wins
// - taking an interrupt latches its vector and level into the latch register
// - first control register holds nesting disable and the trap flags
// - second control register sets external edge polarity and alternate table
// - status word bits 7:5 hold the cpu level, writable by software
// - high level bit in core control is read-only to software
// - level field gives 0..7, or 8..15 with high bit; 111 masks user sources
// - alternate select set makes every interrupt and trap use the alternate table
// - level bits in the status word are read-only while nesting is disabled
// - with the high level bit set all user sources are masked
// Purpose: vectored interrupt and trap controller with AHB-Lite register access
// Assumes: core acks a presented request with irq_ack while irq.valid is high
// Notes: reads take one wait state, writes none; response always OKAY
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module vpi_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [vpi_pkg::NUM_SRC-1:0] src_req,
    input wire logic [vpi_pkg::NUM_EXT-1:0] ext_pin,
    input wire logic [vpi_pkg::NUM_TRAP-1:0] trap_event,
    input wire logic [15:0] core_flags,
    input wire vpi_pkg::vpi_level_load_t level_restore,
    input wire logic irq_ack,
    output vpi_pkg::vpi_irq_req_t irq,
    output logic [3:0] cpu_level,
    output logic [15:0] status_word
);
    import vpi_pkg::*;

    typedef struct packed {
        logic [15:0] gc1;
        logic [15:0] gc2;
        logic [FLAG_W-1:0] flag;
        logic [FLAG_W-1:0] en;
        vpi_prio_arr_t prio;
        logic [15:0] latch;
        logic [NUM_EXT-1:0] ext_prev;
        vpi_phase_t phase;
        logic [5:0] addr_idx;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
        vpi_irq_req_t irq;
    } vpi_state_t;

    vpi_state_t q;
    vpi_state_t d;

    logic arb_found;
    logic [6:0] arb_idx;
    logic [2:0] arb_level;
    logic sw_we;
    logic [15:0] rd_val;
    logic take;
    vpi_level_load_t lvl_load;

    vpi_arbiter u_arb (
        .pending(q.flag[NUM_SRC-1:0] & q.en[NUM_SRC-1:0] & SRC_IMPL[NUM_SRC-1:0]),
        .prio(q.prio),
        .cpu_level(cpu_level),
        .found(arb_found),
        .idx(arb_idx),
        .level(arb_level)
    );

    assign take = q.irq.valid && irq_ack;
    assign sw_we = (q.phase == BUS_WRITE) && hready && (q.addr_idx == IDX_SW);
    assign lvl_load = take ? '{valid: 1'b1, level: q.irq.level} : level_restore;

    vpi_cpu_level u_lvl (
        .clk_sys(clk_sys),
        .rst(rst),
        .sw_we(sw_we),
        .sw_wdata(hwdata[15:0]),
        .nesting_disable(q.gc1[GC1_NEST_BIT]),
        .load(lvl_load),
        .core_flags(core_flags),
        .status_word(status_word),
        .cpu_level(cpu_level)
    );

    // register read mux
    always_comb begin
        int j;
        j = 0;
        rd_val = 16'h0000;
        if (q.addr_idx == IDX_GC1) begin
            rd_val = q.gc1;
        end else if (q.addr_idx == IDX_GC2) begin
            rd_val = q.gc2;
        end else if (q.addr_idx >= IDX_FLAG0 && q.addr_idx < IDX_EN0) begin
            j = int'(q.addr_idx - IDX_FLAG0);
            rd_val = q.flag[j * 16 +: 16];
        end else if (q.addr_idx >= IDX_EN0 && q.addr_idx < IDX_PRIO0) begin
            j = int'(q.addr_idx - IDX_EN0);
            rd_val = q.en[j * 16 +: 16];
        end else if (q.addr_idx >= IDX_PRIO0 && q.addr_idx < IDX_LATCH) begin
            j = int'(q.addr_idx - IDX_PRIO0);
            rd_val = q.prio[j];
        end else if (q.addr_idx == IDX_LATCH) begin
            rd_val = q.latch;
        end else if (q.addr_idx == IDX_SW) begin
            rd_val = status_word;
        end else if (q.addr_idx == IDX_CORE) begin
            rd_val[CORE_HIGH_BIT] = cpu_level[3];
        end
    end

    always_comb begin
        int j;
        logic [FLAG_W-1:0] set;
        logic [15:0] w;
        logic edge_seen;
        logic t_found;
        logic [2:0] t_k;
        logic cand;
        logic [6:0] vec;
        logic [3:0] lvl;
        j = 0;
        set = '0;
        w = hwdata[15:0];
        edge_seen = 1'b0;
        t_found = 1'b0;
        t_k = 3'h0;
        cand = 1'b0;
        vec = 7'h00;
        lvl = 4'h0;
        d = q;

        // data phase of a write
        if (q.phase == BUS_WRITE && hready) begin
            if (q.addr_idx == IDX_GC1) begin
                d.gc1 = w & GC1_RW_MASK;
            end else if (q.addr_idx == IDX_GC2) begin
                d.gc2 = w & GC2_RW_MASK;
            end else if (q.addr_idx >= IDX_FLAG0 && q.addr_idx < IDX_EN0) begin
                j = int'(q.addr_idx - IDX_FLAG0);
                d.flag[j * 16 +: 16] = w;
            end else if (q.addr_idx >= IDX_EN0 && q.addr_idx < IDX_PRIO0) begin
                j = int'(q.addr_idx - IDX_EN0);
                d.en[j * 16 +: 16] = w;
            end else if (q.addr_idx >= IDX_PRIO0 && q.addr_idx < IDX_LATCH) begin
                j = int'(q.addr_idx - IDX_PRIO0);
                d.prio[j] = w & PRIO_FIELD_MASK;
            end
        end

        // data phase of a read: one wait state, data from the register
        d.hready = 1'b1;
        d.hresp = 1'b0;
        if (q.phase == BUS_READ) begin
            d.hrdata = {16'h0000, rd_val};
        end

        // address phase
        if (hsel && htrans[1] && hready) begin
            d.addr_idx = haddr[7:2];
            d.phase = hwrite ? BUS_WRITE : BUS_READ;
            d.hready = hwrite;
        end else begin
            d.phase = BUS_IDLE;
        end

        // external request inputs: polarity bit 0 rising, 1 falling
        for (int k = 0; k < NUM_EXT; k++) begin
            edge_seen = q.gc2[k] ? (q.ext_prev[k] && !ext_pin[k]) : (!q.ext_prev[k] && ext_pin[k]);
            set[EXT_SRC[k]] = set[EXT_SRC[k]] | edge_seen;
        end
        d.ext_prev = ext_pin;

        // hardware set wins over a software clear in the same cycle
        set[NUM_SRC-1:0] = set[NUM_SRC-1:0] | src_req;
        d.flag = (d.flag | set) & SRC_IMPL;
        d.en = d.en & SRC_IMPL;
        for (int k = 0; k < NUM_TRAP; k++) begin
            d.gc1[TRAP_FLAG_POS[k]] = d.gc1[TRAP_FLAG_POS[k]] | trap_event[k];
        end

        // traps: lowest vector first, only above the current level
        for (int k = NUM_TRAP - 1; k >= 0; k--) begin
            if (q.gc1[TRAP_FLAG_POS[k]] && TRAP_LEVEL[k] > cpu_level) begin
                t_found = 1'b1;
                t_k = 3'(k);
            end
        end
        if (t_found) begin
            cand = 1'b1;
            vec = 7'({4'h0, t_k} + 7'h01);
            lvl = TRAP_LEVEL[t_k];
        end else if (arb_found) begin
            cand = 1'b1;
            vec = arb_idx + USER_VEC_BASE;
            lvl = {1'b0, arb_level};
        end
        d.irq.valid = cand && !take;
        d.irq.vector = vec;
        d.irq.level = lvl;
        d.irq.addr = TABLE_BASE + 24'({vec, 1'b0}) + (q.gc2[GC2_ALT_BIT] ? ALT_TABLE_OFFSET : 24'h000000);

        if (take) begin
            d.latch = REG_RESET;
            d.latch[LATCH_VEC_LSB +: 7] = q.irq.vector;
            d.latch[LATCH_LVL_LSB +: 4] = q.irq.level;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
            q.hready <= 1'b1;
            q.phase <= BUS_IDLE;
        end else begin
            q <= d;
        end
    end

    assign hrdata = q.hrdata;
    assign hreadyout = q.hready;
    assign hresp = q.hresp;
    assign irq = q.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    vec_range_a: assert property (irq.valid |-> irq.vector < VEC_RESERVED_FIRST && irq.vector != 7'h00
        && irq.vector != 7'h06 && irq.vector != 7'h07)
        else $error("vector outside the implemented range");
    table_addr_a: assert property (irq.valid && irq.vector == 7'h36 && !$past(q.gc2[GC2_ALT_BIT])
        |-> irq.addr == 24'h000070)
        else $error("primary table address wrong for request 46");
    alt_table_a: assert property (irq.valid && $past(q.gc2[GC2_ALT_BIT])
        |-> irq.addr == 24'({irq.vector, 1'b0}) + 24'h000104)
        else $error("alternate table not used");
    trap_cause_a: assert property (irq.valid && irq.vector < USER_VEC_BASE
        |-> |($past(q.gc1) & (16'h0001 << TRAP_FLAG_POS[irq.vector - 7'h01])))
        else $error("trap vector without its status flag");
    flag_sticky_a: assert property (src_req[3] |=> q.flag[3] ##1 (q.flag[3] || $past(q.phase == BUS_WRITE)))
        else $error("request flag lost");
    enable_gate_a: assert property (d.irq.valid && d.irq.vector >= USER_VEC_BASE
        |-> q.en[int'(d.irq.vector) - 8] && q.flag[int'(d.irq.vector) - 8])
        else $error("disabled or idle source presented");
    prio_field_a: assert property (d.irq.valid && d.irq.vector >= USER_VEC_BASE
        |-> d.irq.level == {1'b0, prio_field(q.prio, int'(d.irq.vector) - 8)})
        else $error("presented level differs from programmed priority");
    level_above_a: assert property (d.irq.valid |-> d.irq.level > cpu_level)
        else $error("request presented at or below cpu level");
    user_masked_a: assert property ((cpu_level[3] || cpu_level[2:0] == 3'h7) && d.irq.valid
        |-> d.irq.vector < USER_VEC_BASE)
        else $error("user source not masked");
    latch_take_a: assert property (take |=> q.latch[6:0] == $past(irq.vector)
        && q.latch[11:8] == $past(irq.level) && cpu_level == $past(irq.level) && !irq.valid)
        else $error("taken vector or level not latched");

endmodule

/* File: logic/vpi_pkg.sv */
// Purpose: constants, register map and carrier types of the vectored interrupt controller
// Assumes: 16-bit registers in the low half of aligned 32-bit bus words
// Notes: index constants are word indices, byte offset is index times four
package vpi_pkg;

    localparam int NUM_SRC = 72;
    localparam int FLAG_W = 80;
    localparam int NUM_FLAG_REG = 5;
    localparam int NUM_PRIO_REG = 18;
    localparam int NUM_TRAP = 5;
    localparam int NUM_EXT = 5;

    localparam logic [6:0] USER_VEC_BASE = 7'h08;
    localparam logic [6:0] VEC_RESERVED_FIRST = 7'h50;
    localparam logic [23:0] TABLE_BASE = 24'h000004;
    localparam logic [23:0] ALT_TABLE_OFFSET = 24'h000100;

    // register word indices
    localparam logic [5:0] IDX_GC1 = 6'h00;
    localparam logic [5:0] IDX_GC2 = 6'h01;
    localparam logic [5:0] IDX_FLAG0 = 6'h02;
    localparam logic [5:0] IDX_EN0 = 6'h07;
    localparam logic [5:0] IDX_PRIO0 = 6'h0C;
    localparam logic [5:0] IDX_LATCH = 6'h1E;
    localparam logic [5:0] IDX_SW = 6'h1F;
    localparam logic [5:0] IDX_CORE = 6'h20;

    localparam int GC1_NEST_BIT = 15;
    localparam int GC2_ALT_BIT = 15;
    localparam int CORE_HIGH_BIT = 3;
    localparam int SW_IPL_LSB = 5;
    localparam int LATCH_VEC_LSB = 0;
    localparam int LATCH_LVL_LSB = 8;

    localparam logic [15:0] GC1_RW_MASK = 16'hFFFE;
    localparam logic [15:0] GC2_RW_MASK = 16'h801F;
    localparam logic [15:0] PRIO_FIELD_MASK = 16'h7777;
    localparam logic [15:0] SW_RW_MASK = 16'h01EF;
    localparam logic [15:0] SW_IPL_MASK = 16'h00E0;
    localparam logic [15:0] SW_RC_MASK = 16'h3400;
    localparam logic [15:0] SW_HW_MASK = 16'hCA10;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [FLAG_W-1:0] SRC_IMPL = 80'h00F6_39FF_DFFF_FFFB_7FFF;

    // trap k has vector k+1; status bit position and fixed level per trap
    localparam logic [NUM_TRAP-1:0][3:0] TRAP_FLAG_POS = {4'h5, 4'h4, 4'h2, 4'h3, 4'h1};
    localparam logic [NUM_TRAP-1:0][3:0] TRAP_LEVEL = {4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    // external request inputs map onto these request numbers
    localparam logic [NUM_EXT-1:0][6:0] EXT_SRC = {7'h36, 7'h35, 7'h1D, 7'h14, 7'h00};

    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} vpi_phase_t;

    typedef logic [NUM_PRIO_REG-1:0][15:0] vpi_prio_arr_t;

    typedef struct packed {
        logic valid;
        logic [6:0] vector;
        logic [3:0] level;
        logic [23:0] addr;
    } vpi_irq_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] level;
    } vpi_level_load_t;

    function automatic logic [2:0] prio_field(input vpi_prio_arr_t p, input int n);
        return p[n / 4][(n % 4) * 4 +: 3];
    endfunction

endpackage

/* File: test/vpi_core_model.sv */
// Purpose: core side that takes presented interrupt requests
// Assumes: ack is raised only while a request is seen and held until it is taken
// Notes: waits DLY cycles of a standing request before acking, so both quick and slow takes occur
`timescale 1ns/1ps
module vpi_core_model
    import vpi_pkg::*;
#(
    parameter int DLY = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire vpi_pkg::vpi_irq_req_t irq,
    input wire logic ack_en,
    output logic irq_ack,
    output vpi_pkg::vpi_irq_req_t got,
    output int takes
);
    int wait_cnt;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_ack <= 1'b0;
            wait_cnt <= 0;
            takes <= 0;
            got <= '0;
        end else if (irq_ack && irq.valid) begin
            got <= irq;
            takes <= takes + 1;
            irq_ack <= 1'b0;
            wait_cnt <= 0;
        end else if (irq.valid && ack_en && wait_cnt >= DLY) begin
            irq_ack <= 1'b1;
        end else begin
            // request withdrawn before the take: drop the ack
            irq_ack <= 1'b0;
            wait_cnt <= irq.valid ? wait_cnt + 1 : 0;
        end
    end
endmodule

/* File: test/vpi_ctrl_tb.sv */
// Purpose: self-checking bench of the interrupt controller over AHB-Lite
// Assumes: hready fed back from hreadyout, core flags held at zero
// Notes: one idle cycle between bus transfers
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module vpi_ctrl_tb;
    import vpi_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [NUM_SRC-1:0] src_req = '0;
    logic [NUM_EXT-1:0] ext_pin = '0;
    logic [NUM_TRAP-1:0] trap_event = '0;
    vpi_level_load_t level_restore = '0;
    logic irq_ack;
    logic ack_en = 1'b0;
    vpi_irq_req_t irq;
    vpi_irq_req_t got;
    int takes;
    logic [3:0] cpu_level;
    logic [15:0] status_word;
    int error_cnt = 0;
    int tests_run = 0;
    int n = 0;

    assign hready = hreadyout;
    always #25 clk_sys = ~clk_sys;

    vpi_ctrl i_vpi_ctrl (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req), .ext_pin(ext_pin),
        .trap_event(trap_event), .core_flags(16'h0000), .level_restore(level_restore),
        .irq_ack(irq_ack), .irq(irq), .cpu_level(cpu_level), .status_word(status_word));
    vpi_core_model #(.DLY(2)) i_vpi_core_model (.clk_sys(clk_sys), .rst(rst), .irq(irq),
        .ack_en(ack_en), .irq_ack(irq_ack), .got(got), .takes(takes));

    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask

    task automatic bus(input logic w, input logic [5:0] idx, input logic [15:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, idx, 2'b00};
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0000, wd};
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [5:0] idx, input logic [15:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, rd);
    endtask

    task automatic chk_rd(input logic [5:0] idx, input logic [15:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 16'h0000, rd);
        `CHK(rd, {16'h0000, exp})
    endtask

    task automatic twait();
        n++;
        while (takes < n) @(posedge clk_sys);
    endtask

    task automatic pulse_src(input logic [NUM_SRC-1:0] s);
        src_req <= s;
        cyc(1);
        src_req <= '0;
    endtask

    task automatic results();
        $display("tests %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        results();
    end

    initial begin
        cyc(20);
        rst <= 1'b0;
        for (int i = 0; i <= 32; i++) chk_rd(6'(i), 16'h0000);
        wr(6'h2A, 16'hFFFF);
        chk_rd(6'h2A, 16'h0000);
        wr(IDX_PRIO0, 16'hFFFF);
        chk_rd(IDX_PRIO0, 16'h7777);
        wr(IDX_PRIO0, 16'h5330);
        pulse_src(72'h8);
        cyc(4);
        chk_rd(IDX_FLAG0, 16'h0008);
        `CHK(irq.valid, 1'b0)
        wr(IDX_EN0, 16'h000F);
        cyc(4);
        `CHK(irq, {1'b1, 7'd11, 4'd5, 24'h00001A})
        ack_en <= 1'b1;
        twait();
        `CHK(got.vector, 7'd11)
        chk_rd(IDX_LATCH, 16'h050B);
        `CHK(cpu_level, 4'h5)
        `CHK(status_word, 16'h00A0)
        `CHK(irq.valid, 1'b0)
        chk_rd(IDX_FLAG0, 16'h0008);
        ack_en <= 1'b0;
        wr(IDX_FLAG0, 16'h0000);
        pulse_src(72'h6);
        wr(IDX_SW, 16'h0000);
        cyc(4);
        `CHK({irq.valid, irq.vector, irq.level}, {1'b1, 7'd9, 4'd3})
        wr(IDX_SW, 16'h0060);
        cyc(4);
        `CHK(irq.valid, 1'b0)
        wr(IDX_PRIO0, 16'h5370);
        wr(IDX_SW, 16'h00E0);
        cyc(4);
        `CHK(irq.valid, 1'b0)
        wr(IDX_SW, 16'h00C0);
        cyc(4);
        `CHK({irq.valid, irq.vector, irq.level}, {1'b1, 7'd9, 4'd7})
        wr(IDX_GC1, 16'h8000);
        wr(IDX_SW, 16'h0000);
        chk_rd(IDX_SW, 16'h00C0);
        chk_rd(IDX_GC1, 16'h8000);
        wr(IDX_GC1, 16'h0000);
        wr(IDX_SW, 16'hFFFF);
        chk_rd(IDX_SW, 16'h01EF);
        wr(IDX_SW, 16'h0000);
        wr(IDX_FLAG0, 16'h0000);
        wr(IDX_PRIO0 + 6'd11, 16'h0600);
        wr(IDX_EN0 + 6'd2, 16'h4000);
        pulse_src(72'h1 << 46);
        cyc(4);
        `CHK({irq.valid, irq.vector, irq.addr}, {1'b1, 7'd54, 24'h000070})
        wr(IDX_GC2, 16'h8000);
        cyc(4);
        `CHK(irq.addr, 24'h000170)
        wr(IDX_EN0 + 6'd2, 16'h0000);
        ack_en <= 1'b1;
        for (int k = 0; k < NUM_TRAP; k++) begin
            trap_event <= 5'(1 << k);
            cyc(1);
            trap_event <= '0;
            twait();
            `CHK(got.vector, 7'(k + 1))
            `CHK(got.level, 4'(14 - k))
            `CHK(got.addr, 24'h000104 + 24'(2 * (k + 1)))
            `CHK(cpu_level[3], 1'b1)
            wr(IDX_GC1, 16'h0000);
            level_restore <= '{valid: 1'b1, level: 4'h0};
            cyc(1);
            level_restore <= '0;
        end
        wr(IDX_EN0 + 6'd2, 16'h4000);
        level_restore <= '{valid: 1'b1, level: 4'h8};
        cyc(1);
        level_restore <= '0;
        cyc(4);
        `CHK(irq.valid, 1'b0)
        chk_rd(IDX_CORE, 16'h0008);
        wr(IDX_CORE, 16'h0000);
        chk_rd(IDX_CORE, 16'h0008);
        level_restore <= '{valid: 1'b1, level: 4'h0};
        cyc(1);
        level_restore <= '0;
        twait();
        `CHK({got.vector, got.addr}, {7'd54, 24'h000170})
        wr(IDX_FLAG0, 16'h0000);
        ext_pin <= 5'h01;
        cyc(4);
        chk_rd(IDX_FLAG0, 16'h0001);
        wr(IDX_GC2, 16'h8001);
        wr(IDX_FLAG0, 16'h0000);
        ext_pin <= 5'h00;
        cyc(4);
        chk_rd(IDX_FLAG0, 16'h0001);
        wr(IDX_FLAG0, 16'hFFFF);
        chk_rd(IDX_FLAG0, 16'h7FFF);
        wr(IDX_FLAG0 + 6'd4, 16'hFFFF);
        chk_rd(IDX_FLAG0 + 6'd4, 16'h00F6);
        results();
    end
endmodule
